// ==== verilog/ccs_pkg.sv ====
// constants, types and state layouts for the common command status unit
package ccs_pkg;

    // queue and group register sizes
    localparam int OQ_DEPTH = 32;
    localparam int OQ_AW = 5;
    localparam int EQ_DEPTH = 8;
    localparam int GRP_COUNT = 9;
    localparam int GRP_W = 16;

    // standard event bit positions; 145 selects power-on, execution error, operation complete
    localparam int PWR_ON_BIT = 7;
    localparam int CMD_ERR_BIT = 5;
    localparam int EXEC_ERR_BIT = 4;
    localparam int OP_DONE_BIT = 0;

    // status byte bit positions
    localparam int SUMMARY_BIT = 5;
    localparam int MSG_AVAIL_BIT = 4;
    localparam int ERR_AVAIL_BIT = 2;

    // values after reset (power cycle)
    localparam logic [7:0] STATUS_LATCH_RST = 8'h80;
    localparam logic [7:0] ENABLE_MASK_RST = 8'h00;

    // characters of the command and response streams
    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_SEMI = 8'h3B;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_QUERY = 8'h3F;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_LOW_A = 8'h61;
    localparam logic [7:0] CH_LOW_Z = 8'h7A;
    localparam logic [7:0] CH_UP_A = 8'h41;
    localparam logic [7:0] CH_UP_Z = 8'h5A;
    localparam logic [7:0] CASE_OFFSET = 8'h20;

    // keywords after upper-casing, right aligned
    localparam logic [31:0] KW_CLEAR = 32'h00434C53;
    localparam logic [31:0] KW_MASK_SET = 32'h00455345;
    localparam logic [31:0] KW_MASK_QRY = 32'h4553453F;
    localparam logic [31:0] KW_STATUS_QRY = 32'h4553523F;
    localparam logic [31:0] KW_IDENT_QRY = 32'h49444E3F;

    // parameter range
    localparam logic [9:0] PARAM_MAX = 10'h0FF;
    localparam logic [9:0] PARAM_SAT = 10'h3E7;

    // identification fields: maker, model, serial, revision; values arbitrary
    localparam int IDN_LEN = 35;
    localparam logic [8*IDN_LEN-1:0] IDN_TEXT = "ACME LABS,MODEL 0000,00000000,00.00";

    // error queue codes, values arbitrary
    localparam logic [7:0] ERR_COMMAND = 8'h01;
    localparam logic [7:0] ERR_RANGE = 8'h02;
    localparam logic [7:0] ERR_OVERFLOW = 8'h03;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_KEY = 3'h1,
        ST_PARAM = 3'h2,
        ST_EXEC = 3'h3,
        ST_SEP = 3'h4,
        ST_RESP = 3'h5,
        ST_TERM = 3'h6
    } ccs_state_e;

    typedef enum logic [0:0] {
        RK_NUM = 1'h0,
        RK_IDN = 1'h1
    } ccs_resp_e;

    typedef struct packed {
        logic valid;
        logic eoi;
        logic [7:0] data;
    } ccs_rx_s;

    typedef struct packed {
        logic [1:0] ndig;
        logic [2:0][7:0] dig;
    } ccs_dig_s;

    typedef logic [GRP_COUNT-1:0][GRP_W-1:0] ccs_grp_t;

    typedef struct packed {
        logic f1;
        logic f2;
        logic f3;
        logic lvl;
    } ccs_sync_s;

    typedef struct packed {
        ccs_state_e state;
        logic [31:0] kw;
        logic [9:0] acc;
        logic has_param;
        logic digits;
        logic bad;
        logic term;
        logic has_resp;
        ccs_resp_e kind;
        logic [7:0] resp_val;
        logic [5:0] idx;
        logic [7:0] status_latch;
        logic [7:0] enable_mask;
        logic [7:0] stb;
        ccs_grp_t grp;
        logic [OQ_DEPTH-1:0][7:0] oq;
        logic [OQ_AW-1:0] oq_wr;
        logic [OQ_AW-1:0] oq_rd;
        logic [OQ_AW:0] oq_cnt;
        logic [EQ_DEPTH-1:0][7:0] eq;
        logic [3:0] eq_cnt;
        logic clr_prev;
    } ccs_core_s;

endpackage : ccs_pkg

// ==== verilog/ccs_sync3.sv ====
// three-stage synchroniser for a pin level, with agreement filter
`timescale 1ns/1ps
module ccs_sync3 import ccs_pkg::*; (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic pin_in,
    output logic level_out
);
    ccs_sync_s r_reg;
    ccs_sync_s r_next;

    // stage one feeds only stage two; level follows once stages two and three agree
    always_comb begin
        r_next = r_reg;
        r_next.f1 = pin_in;
        r_next.f2 = r_reg.f1;
        r_next.f3 = r_reg.f2;
        if (r_reg.f2 == r_reg.f3) begin
            r_next.lvl = r_reg.f3;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r_reg <= '0;
        end else if (ce_in) begin
            r_reg <= r_next;
        end
    end

    assign level_out = r_reg.lvl;
endmodule : ccs_sync3

// ==== verilog/ccs_dec3.sv ====
// binary byte to three ascii decimal digits, leading zeros counted off
`timescale 1ns/1ps
module ccs_dec3 import ccs_pkg::*; (
    input wire logic [7:0] value_in,
    output ccs_dig_s digits_out
);
    // constant divisors keep this small; no state needed
    always_comb begin
        digits_out.dig[2] = CH_ZERO + 8'(value_in / 8'd100);
        digits_out.dig[1] = CH_ZERO + 8'((value_in / 8'd10) % 8'd10);
        digits_out.dig[0] = CH_ZERO + 8'(value_in % 8'd10);
        if (value_in >= 8'd100) begin
            digits_out.ndig = 2'd3;
        end else if (value_in >= 8'd10) begin
            digits_out.ndig = 2'd2;
        end else begin
            digits_out.ndig = 2'd1;
        end
    end
endmodule : ccs_dec3

// ==== verilog/ccs_common_cmd_unit.sv ====
// common command interpreter with standard event status, enable mask and queues
// How it works
// - commands begin with an asterisk; one blank separates keyword from parameter
// - semicolons split one message into commands executed one after another
// - keyword letters are upper-cased, so any case mix is accepted
// - clear-status zeroes the event status latch and the status byte
// - clear-status zeroes questionable group event registers
// - clear-status zeroes operation group event registers
// - clear-status zeroes measurement group event registers
// - clear-status empties the error queue
// - clear-status keeps the enable mask; writing 0 clears it
// - enable-set takes decimal 0 to 255 as the eight-bit mask
// - summary bit set when any latched bit is also enabled
// - enable query answers the mask as a decimal number, zero if empty
// - bit 7 power-on, bit 4 execution error, bit 0 operation complete
// - status query answers the latch in decimal, then clears it
// - enable mask returns to default only on power cycle, never saved
// - identification answers maker, model, serial, revision, comma separated
// - device clear resets the parser and output queue to idle
// - newline, end-or-identify or cr-lf end a message and return to root
`timescale 1ns/1ps
module ccs_common_cmd_unit import ccs_pkg::*; (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input ccs_rx_s rx_in,
    output logic rx_ready_out,
    input wire logic dev_clear_in,
    input wire logic [7:0] event_set_in,
    input ccs_grp_t grp_set_in,
    input wire logic oq_pop_in,
    output logic [7:0] oq_data_out,
    output logic oq_valid_out,
    input wire logic err_pop_in,
    output logic [7:0] err_code_out,
    output logic [3:0] err_count_out,
    output logic [7:0] stb_out,
    output logic [7:0] enable_mask_out,
    output logic [7:0] status_latch_out,
    output ccs_grp_t grp_event_out
);
    ccs_core_s r_reg;
    ccs_core_s r_next;
    ccs_dig_s dig;
    logic clr_level;

    // device clear arrives from the bus pins, outside this clock
    ccs_sync3 u_clr_sync (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .pin_in(dev_clear_in),
        .level_out(clr_level)
    );

    ccs_dec3 u_dec (
        .value_in(r_reg.resp_val),
        .digits_out(dig)
    );

    // input is only taken while the parser is collecting characters
    assign rx_ready_out = (r_reg.state == ST_IDLE) || (r_reg.state == ST_KEY) || (r_reg.state == ST_PARAM);

    always_comb begin
        logic [7:0] ch;
        logic [7:0] up;
        logic is_alpha;
        logic is_digit;
        logic term;
        logic ended;
        logic blank;
        logic do_clear;
        logic clr_latch;
        logic [7:0] set_bits;
        logic push_err;
        logic [7:0] err_code;
        logic push_oq;
        logic [7:0] oq_byte;
        logic last;
        logic [1:0] sel;
        r_next = r_reg;
        ch = rx_in.data;
        is_alpha = ((ch >= CH_LOW_A) && (ch <= CH_LOW_Z)) || ((ch >= CH_UP_A) && (ch <= CH_UP_Z));
        up = ((ch >= CH_LOW_A) && (ch <= CH_LOW_Z)) ? ch - CASE_OFFSET : ch;
        is_digit = (ch >= CH_ZERO) && (ch <= CH_NINE);
        term = (ch == CH_LF) || rx_in.eoi;
        ended = (ch == CH_SEMI) || term;
        blank = (ch == CH_SPACE) || (ch == CH_SEMI) || (ch == CH_CR) || (ch == CH_LF);
        do_clear = 1'b0;
        clr_latch = 1'b0;
        set_bits = 8'h00;
        push_err = 1'b0;
        err_code = ERR_COMMAND;
        push_oq = 1'b0;
        oq_byte = CH_LF;
        last = 1'b0;
        sel = 2'd0;

        // character intake
        if (rx_in.valid && rx_ready_out) begin
            case (r_reg.state)
                ST_IDLE: begin
                    if (ch == CH_STAR || !blank) begin
                        r_next.state = ST_KEY;
                        r_next.kw = 32'h00000000;
                        r_next.acc = 10'h000;
                        r_next.has_param = 1'b0;
                        r_next.digits = 1'b0;
                        r_next.bad = (ch != CH_STAR);
                    end
                end
                ST_KEY: begin
                    if (is_alpha || ch == CH_QUERY) begin
                        if (r_reg.kw[31:24] != 8'h00) begin
                            r_next.bad = 1'b1;
                        end
                        r_next.kw = {r_reg.kw[23:0], up};
                    end else if (ch == CH_SPACE) begin
                        r_next.state = ST_PARAM;
                        r_next.has_param = 1'b1;
                    end else if (!blank) begin
                        r_next.bad = 1'b1;
                    end
                end
                ST_PARAM: begin
                    if (is_digit) begin
                        r_next.digits = 1'b1;
                        if (r_reg.acc > 10'd99) begin
                            r_next.acc = PARAM_SAT;
                        end else begin
                            r_next.acc = 10'(r_reg.acc * 10'd10) + {2'b00, ch - CH_ZERO};
                        end
                    end else if (!blank) begin
                        r_next.bad = 1'b1;
                    end
                end
                default: ;
            endcase
            // separator or terminator closes the current command
            if (ended) begin
                r_next.term = term;
                if (r_next.state == ST_KEY || r_next.state == ST_PARAM) begin
                    r_next.state = ST_EXEC;
                end else if (term) begin
                    r_next.state = r_reg.has_resp ? ST_TERM : ST_IDLE;
                end
            end
        end

        case (r_reg.state)
            // decode and carry out one command
            ST_EXEC: begin
                r_next.state = r_reg.term ? (r_reg.has_resp ? ST_TERM : ST_IDLE) : ST_IDLE;
                if (r_reg.bad) begin
                    push_err = 1'b1;
                    set_bits[CMD_ERR_BIT] = 1'b1;
                end else if (r_reg.kw == KW_CLEAR && !r_reg.has_param) begin
                    do_clear = 1'b1;
                end else if (r_reg.kw == KW_MASK_SET && r_reg.digits) begin
                    if (r_reg.acc > PARAM_MAX) begin
                        push_err = 1'b1;
                        err_code = ERR_RANGE;
                        set_bits[EXEC_ERR_BIT] = 1'b1;
                    end else begin
                        r_next.enable_mask = r_reg.acc[7:0];
                    end
                end else if (r_reg.kw == KW_MASK_QRY && !r_reg.has_param) begin
                    r_next.resp_val = r_reg.enable_mask;
                    r_next.kind = RK_NUM;
                    r_next.state = r_reg.has_resp ? ST_SEP : ST_RESP;
                end else if (r_reg.kw == KW_STATUS_QRY && !r_reg.has_param) begin
                    r_next.resp_val = r_reg.status_latch;
                    r_next.kind = RK_NUM;
                    clr_latch = 1'b1;
                    r_next.state = r_reg.has_resp ? ST_SEP : ST_RESP;
                end else if (r_reg.kw == KW_IDENT_QRY && !r_reg.has_param) begin
                    r_next.kind = RK_IDN;
                    r_next.state = r_reg.has_resp ? ST_SEP : ST_RESP;
                end else begin
                    push_err = 1'b1;
                    set_bits[CMD_ERR_BIT] = 1'b1;
                end
                r_next.idx = 6'd0;
            end
            // answers within one message are joined by semicolons
            ST_SEP: begin
                oq_byte = CH_SEMI;
                push_oq = 1'b1;
            end
            ST_RESP: begin
                if (r_reg.kind == RK_NUM) begin
                    sel = 2'(dig.ndig - 2'd1 - r_reg.idx[1:0]);
                    oq_byte = dig.dig[sel];
                    last = (r_reg.idx[1:0] == 2'(dig.ndig - 2'd1));
                end else begin
                    oq_byte = IDN_TEXT[8 * (IDN_LEN - 1 - int'(r_reg.idx)) +: 8];
                    last = (r_reg.idx == 6'(IDN_LEN - 1));
                end
                push_oq = 1'b1;
            end
            ST_TERM: begin
                oq_byte = CH_LF;
                push_oq = 1'b1;
            end
            default: ;
        endcase

        // output queue stalls the emitter when full, which stalls intake
        if (r_reg.oq_cnt == (OQ_AW + 1)'(OQ_DEPTH)) begin
            push_oq = 1'b0;
        end
        if (oq_pop_in && r_reg.oq_cnt != '0) begin
            r_next.oq_rd = r_reg.oq_rd + 5'h01;
            r_next.oq_cnt = r_next.oq_cnt - 6'h01;
        end
        if (push_oq) begin
            r_next.oq[r_reg.oq_wr] = oq_byte;
            r_next.oq_wr = r_reg.oq_wr + 5'h01;
            r_next.oq_cnt = r_next.oq_cnt + 6'h01;
            case (r_reg.state)
                ST_SEP: begin
                    r_next.state = ST_RESP;
                end
                ST_RESP: begin
                    r_next.has_resp = 1'b1;
                    r_next.idx = r_reg.idx + 6'd1;
                    if (last) begin
                        r_next.state = r_reg.term ? ST_TERM : ST_IDLE;
                    end
                end
                ST_TERM: begin
                    r_next.has_resp = 1'b0;
                    r_next.state = ST_IDLE;
                end
                default: ;
            endcase
        end

        // error queue: head at slot 0, shifts on pop; overflow marks last slot
        if (err_pop_in && r_reg.eq_cnt != 4'd0) begin
            r_next.eq = {8'h00, r_reg.eq[EQ_DEPTH-1:1]};
            r_next.eq_cnt = r_reg.eq_cnt - 4'd1;
        end
        if (push_err) begin
            if (r_next.eq_cnt == 4'(EQ_DEPTH)) begin
                r_next.eq[EQ_DEPTH-1] = ERR_OVERFLOW;
            end else begin
                r_next.eq[r_next.eq_cnt[2:0]] = err_code;
                r_next.eq_cnt = r_next.eq_cnt + 4'd1;
            end
        end

        // clear-status: registers, groups, queues; enable mask untouched
        if (do_clear) begin
            r_next.eq_cnt = 4'd0;
            r_next.oq_cnt = '0;
            r_next.oq_rd = '0;
            r_next.oq_wr = '0;
        end
        // new events win over any clear in the same cycle
        r_next.status_latch = ((do_clear || clr_latch) ? 8'h00 : r_reg.status_latch) | event_set_in | set_bits;
        for (int g = 0; g < GRP_COUNT; g++) begin
            r_next.grp[g] = (do_clear ? '0 : r_reg.grp[g]) | grp_set_in[g];
        end

        // device clear returns the bus side to idle, status kept
        r_next.clr_prev = clr_level;
        if (clr_level && !r_reg.clr_prev) begin
            r_next.state = ST_IDLE;
            r_next.term = 1'b0;
            r_next.has_resp = 1'b0;
            r_next.oq_cnt = '0;
            r_next.oq_rd = '0;
            r_next.oq_wr = '0;
        end

        // status byte follows the new state in the same edge
        r_next.stb = 8'h00;
        r_next.stb[SUMMARY_BIT] = |(r_next.status_latch & r_next.enable_mask);
        r_next.stb[MSG_AVAIL_BIT] = (r_next.oq_cnt != '0);
        r_next.stb[ERR_AVAIL_BIT] = (r_next.eq_cnt != 4'd0);
    end

    // reset stands for power cycle; mask returns to default here only
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r_reg <= '0;
            r_reg.state <= ST_IDLE;
            r_reg.status_latch <= STATUS_LATCH_RST;
            r_reg.enable_mask <= ENABLE_MASK_RST;
        end else if (ce_in) begin
            r_reg <= r_next;
        end
    end

    assign oq_data_out = r_reg.oq[r_reg.oq_rd];
    assign oq_valid_out = (r_reg.oq_cnt != '0);
    assign err_code_out = (r_reg.eq_cnt != 4'd0) ? r_reg.eq[0] : 8'h00;
    assign err_count_out = r_reg.eq_cnt;
    assign stb_out = r_reg.stb;
    assign enable_mask_out = r_reg.enable_mask;
    assign status_latch_out = r_reg.status_latch;
    assign grp_event_out = r_reg.grp;
endmodule : ccs_common_cmd_unit

// ==== tb/ccs_cmd_sva.sv ====
// port-level assertions for the common command unit
`timescale 1ns/1ps
module ccs_cmd_sva import ccs_pkg::*; (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic rx_ready_out,
    input wire logic [7:0] event_set_in,
    input ccs_grp_t grp_set_in,
    input wire logic oq_valid_out,
    input wire logic [3:0] err_count_out,
    input wire logic [7:0] stb_out,
    input wire logic [7:0] enable_mask_out,
    input wire logic [7:0] status_latch_out,
    input ccs_grp_t grp_event_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    // summary bit follows latch and mask with no lag
    a_summary_bit_track: assert property (stb_out[SUMMARY_BIT] == |(status_latch_out & enable_mask_out))
        else $error("summary bit disagrees with latch and mask");
    a_err_flag_track: assert property (stb_out[ERR_AVAIL_BIT] == (err_count_out != 4'h0))
        else $error("error flag disagrees with error count");
    a_msg_flag_track: assert property (stb_out[MSG_AVAIL_BIT] == oq_valid_out)
        else $error("message flag disagrees with output queue");
    // reset stands for a power cycle, so it must win on its own
    a_power_on_state: assert property (disable iff (1'b0) sys_rst_in |->
        status_latch_out == STATUS_LATCH_RST && enable_mask_out == ENABLE_MASK_RST && stb_out == 8'h00)
        else $error("wrong values during reset");
    a_mask_only_exec: assert property ($changed(enable_mask_out) |-> !$past(rx_ready_out))
        else $error("mask changed outside command execution");
    a_event_set_wins: assert property (ce_in && event_set_in != 8'h00 |=>
        (status_latch_out & $past(event_set_in)) == $past(event_set_in))
        else $error("event pulse lost by the latch");
    a_group_set_wins: assert property (ce_in && grp_set_in != '0 |=>
        (grp_event_out & $past(grp_set_in)) == $past(grp_set_in))
        else $error("group event pulse lost");
    a_latch_has_cause: assert property ((status_latch_out & ~$past(status_latch_out) & ~$past(event_set_in)
        & 8'hCF) == 8'h00)
        else $error("latch bit rose without a cause");
    a_err_count_bound: assert property (err_count_out <= 4'(EQ_DEPTH))
        else $error("error count beyond queue depth");
    a_ready_returns: assert property ($fell(rx_ready_out) |-> ##[1:200] rx_ready_out)
        else $error("parser never came back for input");
endmodule : ccs_cmd_sva

bind ccs_common_cmd_unit ccs_cmd_sva ccs_cmd_sva_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .ce_in(ce_in), .rx_ready_out(rx_ready_out), .event_set_in(event_set_in), .grp_set_in(grp_set_in),
    .oq_valid_out(oq_valid_out), .err_count_out(err_count_out), .stb_out(stb_out),
    .enable_mask_out(enable_mask_out), .status_latch_out(status_latch_out), .grp_event_out(grp_event_out));

// ==== tb/ccs_host_model.sv ====
// remote host model: sends command bytes and drains the output queue
`timescale 1ns/1ps
module ccs_host_model import ccs_pkg::*; (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    output ccs_rx_s rx_out,
    input wire logic rx_ready_in,
    output logic oq_pop_out,
    input wire logic oq_valid_in,
    input wire logic [7:0] oq_data_in
);
    string resp = "";

    initial begin
        rx_out = '{valid: 1'b0, eoi: 1'b0, data: 8'hA5};
        oq_pop_out = 1'b0;
    end

    // each byte held from one edge until an edge that sees ready high
    task automatic send(input string s, input bit use_eoi);
        @(posedge clock_in);
        for (int i = 0; i < s.len(); i++) begin
            rx_out.valid <= 1'b1;
            rx_out.data <= s[i];
            rx_out.eoi <= use_eoi && (i == s.len() - 1);
            do begin
                @(posedge clock_in);
            end while (!rx_ready_in); // a stall ends in the watchdog
        end
        rx_out.valid <= 1'b0;
        rx_out.eoi <= 1'b0;
        rx_out.data <= ~s[s.len() - 1]; // released line shows no stale byte
    endtask : send

    // pop every other cycle so each head byte is read before it moves
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            oq_pop_out <= 1'b0;
        end else if (oq_valid_in && !oq_pop_out) begin
            resp = $sformatf("%s%c", resp, oq_data_in);
            oq_pop_out <= 1'b1;
        end else begin
            oq_pop_out <= 1'b0;
        end
    end
endmodule : ccs_host_model

// ==== tb/tb_top.sv ====
// self-checking bench for the common command unit
`timescale 1ns/1ps
module tb_top;
    import ccs_pkg::*;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b0;
    logic ce_in = 1'b1;
    logic dev_clear_in = 1'b0;
    logic err_pop_in = 1'b0;
    logic [7:0] event_set_in = 8'h00;
    ccs_grp_t grp_set_in = '0;
    ccs_rx_s rx;
    logic rx_ready, oq_pop, oq_valid;
    logic [7:0] oq_data, err_code, stb, mask, latch;
    logic [3:0] err_count;
    ccs_grp_t grp_event;
    int fails = 0;
    int checks = 0;

    ccs_common_cmd_unit ccs_common_cmd_unit_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
        .rx_in(rx), .rx_ready_out(rx_ready), .dev_clear_in(dev_clear_in), .event_set_in(event_set_in),
        .grp_set_in(grp_set_in), .oq_pop_in(oq_pop), .oq_data_out(oq_data), .oq_valid_out(oq_valid),
        .err_pop_in(err_pop_in), .err_code_out(err_code), .err_count_out(err_count), .stb_out(stb),
        .enable_mask_out(mask), .status_latch_out(latch), .grp_event_out(grp_event));
    ccs_host_model ccs_host_model_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .rx_out(rx),
        .rx_ready_in(rx_ready), .oq_pop_out(oq_pop), .oq_valid_in(oq_valid), .oq_data_in(oq_data));

    // 20 MHz clock
    initial begin
        forever #25 clock_in = ~clock_in;
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic check_str(input string what, input string exp);
        checks++;
        if (ccs_host_model_inst.resp != exp) begin
            fails++;
            $display("BAD %s expected %s seen %s", what, exp, ccs_host_model_inst.resp);
        end
    endtask : check_str

    // wait until parsing, answering and draining are over; sample mid-cycle
    task automatic settle();
        int n;
        n = 0;
        repeat (4) @(posedge clock_in);
        while ((!rx_ready || oq_valid || oq_pop) && n < 400) begin
            @(posedge clock_in);
            n++;
        end
        if (n >= 400) begin
            fails++; // parser or queue stuck
        end
        @(negedge clock_in);
    endtask : settle

    task automatic cmd(input string s, input bit use_eoi);
        ccs_host_model_inst.resp = "";
        ccs_host_model_inst.send(s, use_eoi);
        settle();
    endtask : cmd

    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // whole run is a few hundred cycles; allow ample margin
    initial begin
        #(50 * 20000);
        fails++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        sys_rst_in <= 1'b1; // a real edge, so the flops reset before the first clock
        repeat (12) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        settle();
        check("latch", latch, STATUS_LATCH_RST);
        check("mask", mask, ENABLE_MASK_RST);
        check("stb", stb, 8'h00);
        $display("test reset done");
        // mixed case keyword, then query back and read the latch
        cmd("*EsE 145\n", 1'b0);
        check("mask", mask, (8'h01 << PWR_ON_BIT) | (8'h01 << EXEC_ERR_BIT) | (8'h01 << OP_DONE_BIT));
        check("summary", stb[SUMMARY_BIT], 1'b1);
        cmd("*ese?\n", 1'b0);
        check_str("mask query", "145\n");
        cmd("*ESR?\n", 1'b0);
        check_str("status query", "128\n");
        check("latch after query", latch, 8'h00);
        check("summary off", stb[SUMMARY_BIT], 1'b0);
        $display("test enable and status done");
        // grouped message with cr-lf, then an eoi ending
        cmd("*ESE 0;*ESE?\r\n", 1'b0);
        check_str("grouped", "0\n");
        cmd("*ESE 33", 1'b1);
        check("mask eoi", mask, 8'h21);
        $display("test grouping done");
        // events, two bad commands, pop one error, then clear status
        @(posedge clock_in);
        ce_in <= 1'b0; // frozen: this pulse must be lost
        event_set_in <= 8'h02;
        @(posedge clock_in);
        ce_in <= 1'b1;
        event_set_in <= 8'h01;
        grp_set_in <= '1;
        @(posedge clock_in);
        event_set_in <= 8'h00;
        grp_set_in <= '0;
        cmd("*FOO\n", 1'b0);
        cmd("*BAR\n", 1'b0);
        check("err count", err_count, 4'h2);
        check("err code", err_code, ERR_COMMAND);
        check("latch", latch, (8'h01 << CMD_ERR_BIT) | (8'h01 << OP_DONE_BIT));
        check("summary", stb[SUMMARY_BIT], 1'b1);
        check("grp set", grp_event[8], 16'hFFFF);
        @(posedge clock_in);
        err_pop_in <= 1'b1;
        @(posedge clock_in);
        err_pop_in <= 1'b0;
        @(negedge clock_in);
        check("err popped", err_count, 4'h1);
        cmd("*cls\n", 1'b0);
        check("latch cls", latch, 8'h00);
        check("stb cls", stb, 8'h00);
        check("questionable", {16'h0000, grp_event[2:0]}, 64'h0);
        check("operation", {16'h0000, grp_event[5:3]}, 64'h0);
        check("measurement", {16'h0000, grp_event[8:6]}, 64'h0);
        check("err cls", err_count, 4'h0);
        check("mask kept", mask, 8'h21);
        $display("test clear status done");
        // out of range value is refused and logged
        cmd("*ESE 256\n", 1'b0);
        check("mask range", mask, 8'h21);
        check("range code", err_code, ERR_RANGE);
        // two answers in one message share one line end
        cmd("*ESE?;*ESR?\n", 1'b0);
        check_str("two answers", "33;16\n");
        cmd("*IDN?\n", 1'b0);
        check_str("identity", $sformatf("%s\n", IDN_TEXT));
        $display("test range and identity done");
        // device clear drops a half-received command
        ccs_host_model_inst.send("*ES", 1'b0);
        @(posedge clock_in);
        dev_clear_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        dev_clear_in <= 1'b0;
        repeat (8) @(posedge clock_in);
        cmd("*ESE?\n", 1'b0);
        check_str("after clear", "33\n");
        $display("test device clear done");
        tally_and_finish();
    end
endmodule : tb_top
